// >>> bench/sls_mem_model.sv
// Purpose: behavioural serial configuration memory on the far side
// Assumes: pins sampled on the core clock
// Notes:   deselected output shows the pull-up level
`timescale 1ns/1ps
module sls_mem_model (
  // clock
  input  wire logic clock,
  // pins from the block
  input  wire logic sel,
  input  wire logic sel_oe,
  input  wire logic sclk,
  // data back to the block
  output logic      sdi
);
  logic [7:0] pat_q;
  logic       sclk_q;
  initial begin
    pat_q  = 8'hA5;
    sclk_q = 1'b0;
    sdi    = 1'b1;
  end
  // shift a pattern on rising serial clock while selected
  always @(posedge clock) begin
    sclk_q <= sclk;
    if (!(sel && sel_oe)) begin
      sdi <= 1'b1;
    end else if (sclk && !sclk_q) begin
      sdi   <= pat_q[7];
      pat_q <= {pat_q[6:0], pat_q[7]};
    end
  end
endmodule // sls_mem_model

// >>> bench/tb_sls_top.sv
// Purpose: self-checking bench for the indicator and strap block
// Assumes: CLK_EN held high except in the freeze test
// Notes:   blink half period is far too long to watch here
`timescale 1ns/1ps
module tb_sls_top;
  import sls_pkg::*;
  logic clock, sys_rst, req_sel, req_dat, tx_i, sc_s, so_s, sdi, en;
  logic [4:0] dc_s, dc_pin, lnk, dco, dcoe, spd;
  logic cs, cs_oe, sck, sck_oe, sdo, sdo_oe, rx, mst, sc_pin, so_pin;
  sls_port_stat_t stat;
  sls_straps_t    straps;
  int bad_count, n_tests;
  ////////////////////////////////////////
  // wire level: design drive wins over the strap resistor
  assign dc_pin = (dcoe & dco) | (~dcoe & dc_s);
  assign sc_pin = sck_oe ? sck : sc_s;
  assign so_pin = sdo_oe ? sdo : so_s;
  sls_top sls_top_inst (.CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(en),
    .PORT_STAT(stat), .DUPLEX_COLLISION_LED_I(dc_pin), .LINK_ACTIVITY_LED(lnk),
    .DUPLEX_COLLISION_LED_O(dco), .DUPLEX_COLLISION_LED_OE(dcoe),
    .PORT_SPEED_LED(spd), .MII_TX_ENABLE_PIN_I(tx_i),
    .CFG_MEM_SERIAL_CLOCK_I(sc_pin), .CFG_MEM_SERIAL_OUT_I(so_pin),
    .CFG_MEM_SERIAL_IN(sdi), .CFG_MEM_SELECT(cs), .CFG_MEM_SELECT_OE(cs_oe),
    .CFG_MEM_SERIAL_CLOCK_O(sck), .CFG_MEM_SERIAL_CLOCK_OE(sck_oe),
    .CFG_MEM_SERIAL_OUT_O(sdo), .CFG_MEM_SERIAL_OUT_OE(sdo_oe),
    .MEM_REQ_SELECT(req_sel), .MEM_REQ_DATA(req_dat), .MEM_RX_DATA(rx),
    .STRAPS(straps), .MEM_MASTER(mst));
  sls_mem_model sls_mem_model_inst (.clock(clock), .sel(cs), .sel_oe(cs_oe),
    .sclk(sck), .sdi(sdi));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  ////////////////////////////////////////
  task chk(string nm, logic [24:0] got, logic [24:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset with given strap levels, then disturb the pins after capture
  task rst_cap(logic [4:0] d, logic t, logic x, logic l);
    sls_straps_t e;
    logic m;
    e = '{d[2], d[0], x, l, {d[1], t}};
    m = ~d[1] & ~t;
    @(posedge clock);
    sys_rst <= 1'b1; dc_s <= d; tx_i <= t; sc_s <= x; so_s <= l;
    repeat (18) @(posedge clock);
    #1;
    chk("rst straps", straps, 6'h30);
    chk("rst oe", {dcoe, cs_oe, sck_oe, sdo_oe}, 8'h00);
    @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("straps", straps, e);
    chk("master", mst, m);
    @(posedge clock);
    dc_s <= ~d; tx_i <= ~t; so_s <= ~l;
    // an outside writer gives one serial clock cycle while select idles
    sc_s <= 1'b1;
    @(posedge clock);
    sc_s <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("held", straps, e);
    chk("idle select", cs, 1'b0);
    chk("mem oe", {cs_oe, sck_oe, sdo_oe}, {3{m}});
    chk("dup oe", dcoe, 5'h1F);
    $display("test strap %h %b done", d, t);
  endtask
  // indicator levels; the blink phase stays low long after reset,
  // so activity and collision both read as lit here
  task led(logic [4:0] ln, logic [4:0] ac, logic [4:0] fd, logic [4:0] co, logic [4:0] sp);
    @(posedge clock);
    stat <= '{ln, ac, fd, co, sp};
    @(posedge clock);
    #1;
    chk("link led", lnk, 5'(~ln));
    chk("dup led", dco, 5'(~fd & ~co));
    chk("speed led", spd, 5'(~sp));
    $display("test led %h done", ln);
  endtask
  // enable low freezes every flop, so a status change waits for the enable
  task frz(logic [4:0] held);
    @(posedge clock);
    en <= 1'b0;
    stat <= '0;
    repeat (3) @(posedge clock);
    #1;
    chk("frozen led", lnk, held);
    @(posedge clock);
    en <= 1'b1;
    @(posedge clock);
    #1;
    chk("thawed led", lnk, 5'h1F);
    $display("test freeze done");
  endtask
  // serial pins: select, data out, clock and data back
  task mem_run(logic m);
    logic p;
    logic tog;
    logic z;
    tog = 1'b0;
    z = 1'b0;
    @(posedge clock);
    req_sel <= 1'b1; req_dat <= 1'b1;
    @(posedge clock);
    req_dat <= 1'b0;
    #1;
    chk("select", cs, m);
    chk("data out", sdo, 1'b1);
    // two rising serial clocks fit in this span, the second shifts out a zero
    repeat (140) begin
      p = sdi;
      @(posedge clock);
      #1;
      chk("data in", rx, p);
      if (sck) tog = 1'b1;
      if (!rx) z = 1'b1;
    end
    chk("sclk", tog, m);
    chk("data in low", z, m);
    @(posedge clock);
    req_sel <= 1'b0;
    $display("test mem %b done", m);
  endtask
  ////////////////////////////////////////
  initial begin
    sys_rst = 1'b1; stat = '0; dc_s = '0; tx_i = 1'b0; sc_s = 1'b0;
    so_s = 1'b0; req_sel = 1'b0; req_dat = 1'b0; bad_count = 0; n_tests = 0;
    en = 1'b1;
    rst_cap(5'h05, 1'b0, 1'b1, 1'b1);
    led(5'h00, 5'h1F, 5'h00, 5'h00, 5'h00);
    led(5'h1F, 5'h00, 5'h1F, 5'h00, 5'h1F);
    led(5'h1B, 5'h11, 5'h13, 5'h0C, 5'h0A);
    frz(5'h04);
    mem_run(1'b1);
    rst_cap(5'h02, 1'b1, 1'b0, 1'b0);
    mem_run(1'b0);
    rst_cap(5'h00, 1'b1, 1'b0, 1'b1);
    rst_cap(5'h06, 1'b0, 1'b1, 1'b0);
    give_verdict;
  end
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clock);
    bad_count++;
    give_verdict;
  end
endmodule // tb_sls_top

// >>> src/sls_pkg.sv
// Purpose: shared constants and carriers for the status indicator and strap latch block
// Assumes: five copper ports, core clock of 125 MHz
// Notes:   all strap defaults follow the internal pull direction of each shared pin
package sls_pkg;

  localparam int SLS_PORTS = 5;

  // blink half period for activity and collision indication
  localparam int SLS_BLINK_MS      = 40;
  localparam int SLS_CLK_MHZ       = 125;
  localparam int SLS_BLINK_CYCLES  = SLS_BLINK_MS * 1000 * SLS_CLK_MHZ;
  localparam int SLS_BLINK_W       = 23;

  // serial clock divider for the configuration memory
  localparam int SLS_SCLK_DIV      = 64;
  localparam int SLS_SCLK_W        = 6;

  // strap reset values, the pull direction of each pin
  localparam logic SLS_BP_RST      = 1'b1;
  localparam logic SLS_AN_RST      = 1'b1;
  localparam logic SLS_XO_RST      = 1'b0;
  localparam logic SLS_LC_RST      = 1'b0;
  localparam logic SLS_AH_RST      = 1'b0;
  localparam logic SLS_AL_RST      = 1'b0;

  // dark level of every indicator, idle level of the memory data input
  localparam logic SLS_LED_OFF     = 1'b1;
  localparam logic SLS_RXD_RST     = 1'b1;

  // per-port line status as seen from the port logic
  typedef struct packed {
    logic [SLS_PORTS-1:0] link_up;
    logic [SLS_PORTS-1:0] activity;
    logic [SLS_PORTS-1:0] full_duplex;
    logic [SLS_PORTS-1:0] collision;
    logic [SLS_PORTS-1:0] speed_100;
  } sls_port_stat_t;

  // latched strap settings
  typedef struct packed {
    logic       backpressure_strap;
    logic       autoneg_strap;
    logic       crossover_strap;
    logic       led_color_strap;
    logic [1:0] chip_addr;
  } sls_straps_t;

endpackage

// >>> src/sls_top.sv
// Purpose: active-low port indicators, strap capture at reset release, memory pin drive
// Assumes: pins synchronous to CLOCK; memory protocol engine drives the serial request inputs
// Notes:   duplex strap pins are read on the same wire that later carries the indicator; other straps come from tx enable and memory pins
`timescale 1ns/1ps
module sls_top
  import sls_pkg::*;
(
  // clock, reset, enable
  input  wire logic                        CLOCK,
  input  wire logic                        SYS_RST,
  input  wire logic                        CLK_EN,
  // port status from the switch core
  input  wire sls_pkg::sls_port_stat_t     PORT_STAT,
  // led pins, inputs carry the strap levels during reset
  input  wire logic [sls_pkg::SLS_PORTS-1:0] DUPLEX_COLLISION_LED_I,
  output logic      [sls_pkg::SLS_PORTS-1:0] LINK_ACTIVITY_LED,
  output logic      [sls_pkg::SLS_PORTS-1:0] DUPLEX_COLLISION_LED_O,
  output logic      [sls_pkg::SLS_PORTS-1:0] DUPLEX_COLLISION_LED_OE,
  output logic      [sls_pkg::SLS_PORTS-1:0] PORT_SPEED_LED,
  // lower address strap on the tx enable pin
  input  wire logic                        MII_TX_ENABLE_PIN_I,
  // configuration memory pins
  input  wire logic                        CFG_MEM_SERIAL_CLOCK_I,
  input  wire logic                        CFG_MEM_SERIAL_OUT_I,
  input  wire logic                        CFG_MEM_SERIAL_IN,
  output logic                             CFG_MEM_SELECT,
  output logic                             CFG_MEM_SELECT_OE,
  output logic                             CFG_MEM_SERIAL_CLOCK_O,
  output logic                             CFG_MEM_SERIAL_CLOCK_OE,
  output logic                             CFG_MEM_SERIAL_OUT_O,
  output logic                             CFG_MEM_SERIAL_OUT_OE,
  // serial request from the memory read engine
  input  wire logic                        MEM_REQ_SELECT,
  input  wire logic                        MEM_REQ_DATA,
  output logic                             MEM_RX_DATA,
  // latched settings
  output sls_pkg::sls_straps_t             STRAPS,
  output logic                             MEM_MASTER
);
  import sls_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // blink timebase shared by all ports
  logic [SLS_BLINK_W-1:0] blink_cnt_q, blink_cnt_d;
  logic                   blink_q, blink_d;

  // one shared toggle keeps every port blinking in step, at the cost of phase freedom
  always_comb begin
    blink_cnt_d = blink_cnt_q + 1'b1;
    blink_d     = blink_q;
    if (blink_cnt_q == SLS_BLINK_W'(SLS_BLINK_CYCLES - 1)) begin
      blink_cnt_d = '0;
      blink_d     = ~blink_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else if (CLK_EN) begin
      blink_cnt_q <= blink_cnt_d;
      blink_q     <= blink_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap capture
  logic        in_rst_q;
  sls_straps_t straps_q, straps_d;
  logic        master_q, master_d;

  // straps are taken from the pins in the first enabled cycle after reset release only
  always_comb begin
    straps_d = straps_q;
    master_d = master_q;
    if (in_rst_q) begin
      straps_d.backpressure_strap = DUPLEX_COLLISION_LED_I[2];
      straps_d.autoneg_strap      = DUPLEX_COLLISION_LED_I[0];
      straps_d.crossover_strap    = CFG_MEM_SERIAL_CLOCK_I;
      straps_d.led_color_strap    = CFG_MEM_SERIAL_OUT_I;
      straps_d.chip_addr          = {DUPLEX_COLLISION_LED_I[1],
                                     MII_TX_ENABLE_PIN_I};
      master_d = ~DUPLEX_COLLISION_LED_I[1] & ~MII_TX_ENABLE_PIN_I;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      in_rst_q <= 1'b1;
      straps_q <= '{SLS_BP_RST, SLS_AN_RST, SLS_XO_RST, SLS_LC_RST, {SLS_AH_RST, SLS_AL_RST}};
      master_q <= ~SLS_AH_RST & ~SLS_AL_RST;
    end else if (CLK_EN) begin
      in_rst_q <= 1'b0;
      straps_q <= straps_d;
      master_q <= master_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator outputs
  logic [SLS_PORTS-1:0] lnk_d, lnk_q, dup_d, dup_q, spd_d, spd_q, dup_oe_q;

  generate
    for (genvar p = 0; p < SLS_PORTS; p++) begin : g_port
      always_comb begin
        if (!PORT_STAT.link_up[p])
          lnk_d[p] = 1'b1;
        else if (PORT_STAT.activity[p])
          lnk_d[p] = blink_q;
        else
          lnk_d[p] = 1'b0;
        if (PORT_STAT.collision[p])
          dup_d[p] = blink_q;
        else
          dup_d[p] = ~PORT_STAT.full_duplex[p];
        spd_d[p] = ~PORT_STAT.speed_100[p];
      end
    end
  endgenerate

  // duplex pins are released during reset so the strap levels can be read
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      lnk_q    <= {SLS_PORTS{SLS_LED_OFF}};
      dup_q    <= {SLS_PORTS{SLS_LED_OFF}};
      spd_q    <= {SLS_PORTS{SLS_LED_OFF}};
      dup_oe_q <= '0;
    end else if (CLK_EN) begin
      lnk_q    <= lnk_d;
      dup_q    <= dup_d;
      spd_q    <= spd_d;
      dup_oe_q <= {SLS_PORTS{~in_rst_q}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration memory pins
  logic [SLS_SCLK_W-1:0] sclk_cnt_q, sclk_cnt_d;
  logic sclk_q, sclk_d, cs_q, cs_d, sdo_q, sdo_d, oe_q, rxd_q;

  // serial clock runs only while this device is memory master
  always_comb begin
    sclk_cnt_d = sclk_cnt_q + 1'b1;
    sclk_d     = sclk_q;
    if (sclk_cnt_q == SLS_SCLK_W'(SLS_SCLK_DIV / 2 - 1)) begin
      sclk_cnt_d = '0;
      sclk_d     = ~sclk_q & master_q;
    end
    cs_d  = MEM_REQ_SELECT & master_q;
    sdo_d = MEM_REQ_DATA;
  end

  // pins float while reset holds; when not master an external writer owns them
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sclk_cnt_q <= '0;
      sclk_q     <= 1'b0;
      cs_q       <= 1'b0;
      sdo_q      <= 1'b0;
      oe_q       <= 1'b0;
      rxd_q      <= SLS_RXD_RST;
    end else if (CLK_EN) begin
      sclk_cnt_q <= sclk_cnt_d;
      sclk_q     <= sclk_d;
      cs_q       <= cs_d;
      sdo_q      <= sdo_d;
      oe_q       <= ~in_rst_q & master_q;
      rxd_q      <= CFG_MEM_SERIAL_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign LINK_ACTIVITY_LED       = lnk_q;
  assign DUPLEX_COLLISION_LED_O  = dup_q;
  assign DUPLEX_COLLISION_LED_OE = dup_oe_q;
  assign PORT_SPEED_LED          = spd_q;
  assign CFG_MEM_SELECT          = cs_q;
  assign CFG_MEM_SELECT_OE       = oe_q;
  assign CFG_MEM_SERIAL_CLOCK_O  = sclk_q;
  assign CFG_MEM_SERIAL_CLOCK_OE = oe_q;
  assign CFG_MEM_SERIAL_OUT_O    = sdo_q;
  assign CFG_MEM_SERIAL_OUT_OE   = oe_q;
  assign MEM_RX_DATA             = rxd_q;
  assign STRAPS                  = straps_q;
  assign MEM_MASTER              = master_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_link_off: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    CLK_EN && !PORT_STAT.link_up[0] |=> LINK_ACTIVITY_LED[0])
    else $error("link led not dark without link");
  chk_link_idle: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    CLK_EN && PORT_STAT.link_up[1] && !PORT_STAT.activity[1] |=> !LINK_ACTIVITY_LED[1])
    else $error("link led not lit on idle link");
  chk_dup_full: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    CLK_EN && !PORT_STAT.collision[2] |=>
      DUPLEX_COLLISION_LED_O[2] == !$past(PORT_STAT.full_duplex[2]))
    else $error("duplex led wrong");
  chk_speed_led: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    CLK_EN |=> PORT_SPEED_LED[3] == !$past(PORT_STAT.speed_100[3]))
    else $error("speed led wrong");
  chk_strap_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !in_rst_q && !$past(in_rst_q) |-> $stable(STRAPS))
    else $error("straps changed after capture");
  chk_strap_take: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    in_rst_q && CLK_EN |=> STRAPS.backpressure_strap == $past(DUPLEX_COLLISION_LED_I[2]))
    else $error("back pressure strap not captured");
  chk_master_sel: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !in_rst_q |-> MEM_MASTER == (STRAPS.chip_addr == 2'h0))
    else $error("master select disagrees with address");
  chk_pins_float: assert property (@(posedge CLOCK)
    SYS_RST |=> !CFG_MEM_SELECT_OE && !CFG_MEM_SERIAL_CLOCK_OE && !CFG_MEM_SERIAL_OUT_OE)
    else $error("memory pins driven in reset");
  chk_cs_slave: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !MEM_MASTER |=> !CFG_MEM_SELECT)
    else $error("select driven while not master");

endmodule // sls_top
